// >>> hdl/acsd_top.v
// Three-wire control bus decoder for a stereo audio control device.
// Assumes the bus clock is far slower than i_ref_clk (bench runs the bus at 6.25 MHz, 20 local clocks per bit).
`timescale 1ns/100ps
`include "acsd_consts.vh"
module acsd_top (
   input wire i_ref_clk, // 125 MHz local clock
   input wire i_nrst, // Synchronous reset, active low
   input wire i_bus_clk, // Control bus clock pin
   input wire i_identity_strobe_n, // Identity strobe pin, low for address
   input wire i_data_in, // Data line level as seen on the pin
   output reg o_data_out, // Data line drive value, always low
   output reg o_data_oe, // Data line pull-down enable, high drives
   input wire i_flag_one_n, // Flag input one, active low
   input wire i_flag_two_n, // Flag input two, active low
   output reg [1:0] o_source_sel, // Selected source 0..2, 3 when muted
   output reg o_mute, // Mute active
   output reg [1:0] o_mode, // 0 stereo, 1 left mono, 2 right mono
   output reg [5:0] o_att_left, // Left attenuation in 2 dB steps
   output reg [5:0] o_att_right, // Right attenuation in 2 dB steps
   output reg o_loudness, // Loudness on
   output reg [3:0] o_bass, // Bass code
   output reg [3:0] o_treble, // Treble code
   output reg o_cmd_done // One-cycle pulse per executed write
);
   ////////////////////////////////////////////////////////////////////////////
   // Pin synchronisation and edge detection
   wire [`ACSD_LANES-1:0] pins_sync;
   reg clk_prev;
   reg stb_prev;
   wire bus_rise;
   wire bus_fall;
   wire xfer_start;

   // Pins treated as pulled high at reset so no false edge appears
   acsd_sync #(
      .WIDTH(`ACSD_LANES),
      .RST_VAL({`ACSD_LANES{1'b1}})
   ) u_sync (
      .i_ref_clk(i_ref_clk),
      .i_nrst(i_nrst),
      .i_async({i_flag_two_n, i_flag_one_n, i_data_in, i_identity_strobe_n, i_bus_clk}),
      .o_sync(pins_sync)
   );

   always @(posedge i_ref_clk) begin
      if (!i_nrst) begin
         clk_prev <= 1'b1;
         stb_prev <= 1'b1;
      end else begin
         clk_prev <= pins_sync[`ACSD_LN_CLK];
         stb_prev <= pins_sync[`ACSD_LN_STB];
      end
   end

   assign bus_rise = pins_sync[`ACSD_LN_CLK] & ~clk_prev;
   assign bus_fall = ~pins_sync[`ACSD_LN_CLK] & clk_prev;
   assign xfer_start = ~pins_sync[`ACSD_LN_STB] & stb_prev;

   ////////////////////////////////////////////////////////////////////////////
   // Shift register and bit counter
   reg [4:0] bit_cnt;
   reg [7:0] addr;
   reg [7:0] value;
   reg addr_ok;
   reg [7:0] rd_word;
   wire addr_phase;
   wire value_phase;
   wire [7:0] addr_next;
   wire [7:0] value_next;
   wire [4:0] cnt_inc;
   wire [2:0] rd_idx;

   assign addr_phase = (bit_cnt < `ACSD_BYTE_BITS);
   assign value_phase = (bit_cnt >= `ACSD_BYTE_BITS) && (bit_cnt < `ACSD_XFER_BITS);
   assign addr_next = {addr[6:0], pins_sync[`ACSD_LN_DAT]};
   assign value_next = {value[6:0], pins_sync[`ACSD_LN_DAT]};
   assign cnt_inc = bit_cnt + 5'h01;
   // Value bits go out MSB first, so bit index counts down
   assign rd_idx = 3'h7 - bit_cnt[2:0];

   always @(posedge i_ref_clk) begin
      if (!i_nrst) begin
         bit_cnt <= `ACSD_XFER_BITS;
         addr <= 8'h00;
         value <= 8'h00;
         addr_ok <= 1'b0;
         rd_word <= 8'hff;
      end else if (xfer_start) begin
         bit_cnt <= 5'h00;
         addr_ok <= 1'b0;
      end else if (bus_rise && (bit_cnt < `ACSD_XFER_BITS)) begin
         bit_cnt <= cnt_inc;
         if (addr_phase) begin
            // Address bits only shift in while the strobe holds low; bit_cnt advances regardless
            if (!pins_sync[`ACSD_LN_STB]) begin
               addr <= addr_next;
            end
            if (cnt_inc == `ACSD_BYTE_BITS) begin
               addr_ok <= (addr_next[7:3] == `ACSD_ADDR_BASE);
               // Raw pin levels reported; unused bits read as released
               rd_word <= {6'h3f, pins_sync[`ACSD_LN_F2], pins_sync[`ACSD_LN_F1]};
            end
         end else begin
            value <= value_next;
         end
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Read-back drive on the open-drain data line
   // Changing on the falling edge keeps data stable around the next rise
   wire read_sel;
   assign read_sel = addr_ok && (addr[2:0] == `ACSD_FN_READ);

   always @(posedge i_ref_clk) begin
      if (!i_nrst) begin
         o_data_out <= 1'b0;
         o_data_oe <= 1'b0;
      end else begin
         o_data_out <= 1'b0;
         if (xfer_start || !value_phase || !read_sel) begin
            o_data_oe <= 1'b0;
         end else if (bus_fall) begin
            o_data_oe <= ~rd_word[rd_idx];
         end
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Command execution
   wire exec;
   wire [5:0] att_code;
   assign exec = bus_rise && (cnt_inc == `ACSD_XFER_BITS) && addr_ok && !addr_phase;
   // Codes 101xxx and 11xxxx all floor at the -80 dB step
   assign att_code = (value_next[5:0] >= `ACSD_ATT_MAX) ? `ACSD_ATT_MAX : value_next[5:0];

   always @(posedge i_ref_clk) begin
      if (!i_nrst) begin
         o_source_sel <= `ACSD_SEL_MUTE;
         o_mute <= 1'b1;
         o_mode <= `ACSD_MODE_STEREO;
         o_att_left <= `ACSD_ATT_MAX;
         o_att_right <= `ACSD_ATT_MAX;
         o_loudness <= 1'b0;
         o_bass <= `ACSD_TONE_FLAT;
         o_treble <= `ACSD_TONE_FLAT;
         o_cmd_done <= 1'b0;
      end else begin
         o_cmd_done <= exec && (addr[2:0] != `ACSD_FN_READ);
         if (exec) begin
            case (addr[2:0])
               `ACSD_FN_INPUT: begin
                  o_source_sel <= value_next[1:0];
                  o_mute <= (value_next[1:0] == `ACSD_SEL_MUTE);
               end
               `ACSD_FN_LOUD: begin
                  o_loudness <= value_next[0];
               end
               `ACSD_FN_BASS: begin
                  o_bass <= value_next[3:0];
               end
               `ACSD_FN_TREBLE: begin
                  o_treble <= value_next[3:0];
               end
               `ACSD_FN_VOL_L: begin
                  o_att_left <= att_code;
               end
               `ACSD_FN_VOL_R: begin
                  o_att_right <= att_code;
               end
               `ACSD_FN_MODE: begin
                  // Codes 0xx are undefined and leave the mode alone
                  if (value_next[2:1] == 2'h3) begin
                     o_mode <= `ACSD_MODE_RIGHT;
                  end else if (value_next[2:0] == `ACSD_MV_STEREO) begin
                     o_mode <= `ACSD_MODE_STEREO;
                  end else if (value_next[2:0] == `ACSD_MV_LEFT) begin
                     o_mode <= `ACSD_MODE_LEFT;
                  end
               end
               default: begin
                  o_mode <= o_mode; // Read function changes no setting
               end
            endcase
         end
      end
   end
endmodule

// >>> hdl/acsd_consts.vh
// Constants for the audio control serial decoder.
// Assumes inclusion by bare name from the design files only.
`ifndef ACSD_CONSTS_VH
`define ACSD_CONSTS_VH

// Transfer shape
`define ACSD_BYTE_BITS 5'h08
`define ACSD_XFER_BITS 5'h10
// Upper five address bits that select this device (40h..47h)
`define ACSD_ADDR_BASE 5'h08
// Function codes held in the three low address bits
`define ACSD_FN_INPUT 3'h0
`define ACSD_FN_LOUD 3'h1
`define ACSD_FN_BASS 3'h2
`define ACSD_FN_TREBLE 3'h3
`define ACSD_FN_VOL_L 3'h4
`define ACSD_FN_VOL_R 3'h5
`define ACSD_FN_MODE 3'h6
`define ACSD_FN_READ 3'h7
// Input selector codes
`define ACSD_SEL_MUTE 2'h3
// Mode codes on the mode output
`define ACSD_MODE_STEREO 2'h0
`define ACSD_MODE_LEFT 2'h1
`define ACSD_MODE_RIGHT 2'h2
// Mode value field codes
`define ACSD_MV_LEFT 3'h4
`define ACSD_MV_STEREO 3'h5
// Attenuation in 2 dB steps; 40 steps is the -80 dB floor
`define ACSD_ATT_MAX 6'h28
// Tone flat code
`define ACSD_TONE_FLAT 4'h6
// Synchroniser lane positions
`define ACSD_LN_CLK 0
`define ACSD_LN_STB 1
`define ACSD_LN_DAT 2
`define ACSD_LN_F1 3
`define ACSD_LN_F2 4
`define ACSD_LANES 5

`endif

// >>> hdl/acsd_sync.v
// Two flip-flop synchroniser bank for asynchronous pins.
// Assumes inputs are quasi-static levels relative to i_ref_clk.
`timescale 1ns/100ps
module acsd_sync #(
   parameter WIDTH = 5,
   parameter [WIDTH-1:0] RST_VAL = {WIDTH{1'b1}}
) (
   input wire i_ref_clk, // Local clock
   input wire i_nrst, // Synchronous reset, active low
   input wire [WIDTH-1:0] i_async, // Raw pin levels
   output reg [WIDTH-1:0] o_sync // Synchronised levels
);
   reg [WIDTH-1:0] meta;

   always @(posedge i_ref_clk) begin
      if (!i_nrst) begin
         meta <= RST_VAL;
         o_sync <= RST_VAL;
      end else begin
         meta <= i_async;
         o_sync <= meta;
      end
   end
endmodule

// >>> tb/acsd_checker.sv
// Port-level checks for the serial decoder.
// Assumes binding to acsd_top, one clock domain.
`timescale 1ns/100ps
module acsd_checker (
   input wire i_ref_clk, // Clock
   input wire i_nrst, // Reset
   input wire o_data_out, // Drive value
   input wire o_data_oe, // Pull-down on
   input wire [1:0] o_source_sel, // Source
   input wire o_mute, // Mute
   input wire [1:0] o_mode, // Mode
   input wire [5:0] o_att_left, // Left att
   input wire [5:0] o_att_right, // Right att
   input wire o_loudness, // Loudness
   input wire [3:0] o_bass, // Bass
   input wire [3:0] o_treble, // Treble
   input wire o_cmd_done // Executed
);
   wire [24:0] settings = {o_source_sel, o_mode, o_att_left, o_att_right, o_loudness, o_bass, o_treble};
   default clocking cb @(posedge i_ref_clk); endclocking
   default disable iff (!i_nrst);
   //////////////////////////////////////////////////////////////////
   drive_low_a: assert property (o_data_out == 1'b0) else $error("data drive not low");
   mute_tracks_a: assert property (o_mute == (o_source_sel == 2'h3)) else $error("mute mismatch");
   att_floor_a: assert property (o_att_left <= 6'h28 && o_att_right <= 6'h28) else $error("att range");
   mode_code_a: assert property (o_mode != 2'h3) else $error("bad mode");
   change_cause_a: assert property (!$stable(settings) |-> o_cmd_done) else $error("stray change");
   done_single_a: assert property (o_cmd_done |=> !o_cmd_done) else $error("long done");
   write_quiet_a: assert property (o_cmd_done |-> !o_data_oe) else $error("drive on write");
   reset_vals_a: assert property ($rose(i_nrst) |-> o_mute && o_att_left == 6'h28 && o_att_right == 6'h28
      && o_mode == 2'h0 && o_bass == 4'h6 && o_treble == 4'h6 && !o_loudness) else $error("reset values");
   cover property (o_cmd_done && o_att_left == 6'h14);
   cover property (o_data_oe);
   cover property (o_mode == 2'h2);
endmodule
bind acsd_top acsd_checker acsd_checker_inst (.i_ref_clk(i_ref_clk), .i_nrst(i_nrst), .o_data_out(o_data_out),
   .o_data_oe(o_data_oe), .o_source_sel(o_source_sel), .o_mute(o_mute), .o_mode(o_mode), .o_att_left(o_att_left),
   .o_att_right(o_att_right), .o_loudness(o_loudness), .o_bass(o_bass), .o_treble(o_treble), .o_cmd_done(o_cmd_done));

// >>> tb/acsd_host_model.sv
// Bus master model: clock, strobe, open-drain data.
// Assumes a pull-up on the resolved line; bus clock idles high.
`timescale 1ns/100ps
module acsd_host_model (
   output reg o_bus_clk, // Bus clock
   output reg o_strobe_n, // Identity strobe
   output reg o_pull_low, // Pull-down enable
   input wire i_line // Resolved data line
);
   initial begin
      o_bus_clk = 1'b1;
      o_strobe_n = 1'b1;
      o_pull_low = 1'b0;
   end
   // 160 ns bit; the offset keeps pin edges off the local clock edges
   task xfer(input [15:0] word, input rd_mode, output [7:0] rd);
      integer i;
      begin
         #3;
         o_strobe_n = 1'b0;
         for (i = 15; i >= 0; i = i - 1) begin
            if (i == 7)
               o_strobe_n = 1'b1;
            o_bus_clk = 1'b0;
            o_pull_low = !word[i] && !(rd_mode && i < 8);
            #80;
            o_bus_clk = 1'b1;
            if (i < 8)
               rd[i] = i_line;
            #80;
         end
         o_pull_low = 1'b0;
         #237;
      end
   endtask
endmodule

// >>> tb/tb.sv
// Self-checking bench for acsd_top.
// Assumes acsd_host_model masters the bus; line resolved here.
`timescale 1ns/100ps
module tb;
   reg i_ref_clk = 1'b0;
   reg i_nrst = 1'b0;
   reg i_flag_one_n = 1'b1;
   reg i_flag_two_n = 1'b1;
   wire bus_clk, strobe_n, pull_low, o_data_out, o_data_oe, o_mute, o_loudness, o_cmd_done;
   wire [1:0] o_source_sel, o_mode;
   wire [5:0] o_att_left, o_att_right;
   wire [3:0] o_bass, o_treble;
   wire line = (pull_low || (o_data_oe && !o_data_out)) ? 1'b0 : 1'b1;
   integer n_fail = 0;
   integer cmp_count = 0;
   integer k;
   reg [7:0] d;
   reg [1:0] e_sel = 2'h3;
   reg [1:0] e_mode = 2'h0;
   reg [5:0] e_al = 6'h28;
   reg [5:0] e_ar = 6'h28;
   reg e_loud = 1'b0;
   reg [3:0] e_bass = 4'h6;
   reg [3:0] e_treb = 4'h6;
   acsd_host_model acsd_host_model_inst (.o_bus_clk(bus_clk), .o_strobe_n(strobe_n), .o_pull_low(pull_low),
      .i_line(line));
   acsd_top acsd_top_inst (.i_ref_clk(i_ref_clk), .i_nrst(i_nrst), .i_bus_clk(bus_clk),
      .i_identity_strobe_n(strobe_n), .i_data_in(line), .o_data_out(o_data_out), .o_data_oe(o_data_oe),
      .i_flag_one_n(i_flag_one_n), .i_flag_two_n(i_flag_two_n), .o_source_sel(o_source_sel), .o_mute(o_mute),
      .o_mode(o_mode), .o_att_left(o_att_left), .o_att_right(o_att_right), .o_loudness(o_loudness),
      .o_bass(o_bass), .o_treble(o_treble), .o_cmd_done(o_cmd_done));
   initial begin
      forever #4 i_ref_clk = ~i_ref_clk;
   end
   //////////////////////////////////////////////////////////////////
   task check(input [31:0] exp, input [31:0] got);
      begin
         cmp_count = cmp_count + 1;
         if (got !== exp) begin
            n_fail = n_fail + 1;
            $display("MISMATCH t=%0t exp=%h got=%h", $time, exp, got);
         end
      end
   endtask
   // Whole state compared every time, so side effects show up
   task chk_state;
      check({e_sel, e_sel == 2'h3, e_mode, e_al, e_ar, e_loud, e_bass, e_treb},
         {o_source_sel, o_mute, o_mode, o_att_left, o_att_right, o_loudness, o_bass, o_treble});
   endtask
   task cmd(input [7:0] a, input [7:0] v);
      begin
         acsd_host_model_inst.xfer({a, v}, 1'b0, d);
         chk_state;
      end
   endtask
   task print_verdict;
      begin
         $display("Comparisons %0d mismatches %0d", cmp_count, n_fail);
         if (n_fail == 0 && cmp_count > 0)
            $display("Testbench passed");
         else
            $display("Testbench failed");
         $finish;
      end
   endtask
   //////////////////////////////////////////////////////////////////
   task test_reset;
      begin
         repeat (16) @(posedge i_ref_clk);
         i_nrst <= 1'b1;
         repeat (8) @(posedge i_ref_clk);
         chk_state;
         $display("reset test done");
      end
   endtask
   task test_input;
      begin
         for (k = 0; k < 4; k = k + 1) begin
            e_sel = k[1:0];
            cmd(8'h40, {6'h3f, k[1:0]});
         end
         $display("input test done");
      end
   endtask
   task test_volume;
      begin
         e_al = 6'h14;
         cmd(8'h44, 8'hd4);
         e_ar = 6'h00;
         cmd(8'h45, 8'hc0);
         e_al = 6'h28;
         cmd(8'h44, 8'h2b);
         e_ar = 6'h28;
         cmd(8'h45, 8'h3f);
         e_al = 6'h27;
         cmd(8'h44, 8'h27);
         $display("volume test done");
      end
   endtask
   task test_mode;
      begin
         e_mode = 2'h2;
         cmd(8'h46, 8'h06);
         e_mode = 2'h1;
         cmd(8'h46, 8'hfc);
         e_mode = 2'h2;
         cmd(8'h46, 8'h07);
         cmd(8'h46, 8'h03);
         e_mode = 2'h0;
         cmd(8'h46, 8'h05);
         $display("mode test done");
      end
   endtask
   task test_function;
      begin
         e_loud = 1'b1;
         cmd(8'h41, 8'hff);
         e_bass = 4'h9;
         cmd(8'h42, 8'hf9);
         e_treb = 4'h3;
         cmd(8'h43, 8'h03);
         cmd(8'h48, 8'h00);
         cmd(8'h3f, 8'hc1);
         $display("function test done");
      end
   endtask
   task test_read;
      begin
         for (k = 0; k < 4; k = k + 1) begin
            @(posedge i_ref_clk);
            i_flag_one_n <= k[0];
            i_flag_two_n <= k[1];
            acsd_host_model_inst.xfer(16'h4700, 1'b1, d);
            check({6'h3f, k[1:0]}, d);
            chk_state;
         end
         $display("read test done");
      end
   endtask
   initial begin
      test_reset;
      test_input;
      test_volume;
      test_mode;
      test_function;
      test_read;
      print_verdict;
   end
   initial begin
      #400000;
      n_fail = n_fail + 1;
      print_verdict;
   end
endmodule
